//--- rtl/atpopc_pkg.sv
// Constants and types for the converter control block
package atpopc_pkg;

  // Register addresses (7-bit word address)
  localparam logic [6:0] ADDR_MODE_CTRL    = 7'h01;
  localparam logic [6:0] ADDR_CORR_CTRL_A  = 7'h03;
  localparam logic [6:0] ADDR_CORR_CTRL_B  = 7'h1A;
  localparam logic [6:0] ADDR_OVR_THRESH   = 7'h2F;
  localparam logic [6:0] ADDR_SLEEP_CTRL   = 7'h37;
  localparam logic [6:0] ADDR_PAT_CTRL     = 7'h3C;
  localparam logic [6:0] ADDR_PAT_VALUE    = 7'h3D;
  localparam logic [6:0] ADDR_PAT_AUX      = 7'h3E;

  // Field positions
  localparam int CORR_EN_BIT      = 15;
  localparam int HP1_BIT          = 1;
  localparam int RESTART_BIT      = 14;
  localparam int SLEEP_STATE_LSB  = 4;

  // Reset values
  localparam logic [3:0]  THRESH_RESET  = 4'hF;
  localparam logic        HP1_RESET     = 1'b1;
  localparam logic [15:0] PAT_RESET     = 16'h0000;

  // Pattern register encodings
  localparam logic [15:0] PAT_ZERO_C = 16'h8000;
  localparam logic [15:0] PAT_ZERO_V = 16'h0000;
  localparam logic [15:0] PAT_ZERO_A = 16'h0000;
  localparam logic [15:0] PAT_ONE_C  = 16'hBFFC;
  localparam logic [15:0] PAT_ONE_V  = 16'h3FFC;
  localparam logic [15:0] PAT_ONE_A  = 16'h3FFC;
  localparam logic [15:0] PAT_TAA_C  = 16'h9554;
  localparam logic [15:0] PAT_TAA_V  = 16'h2AA8;
  localparam logic [15:0] PAT_TAA_A  = 16'h1554;
  localparam logic [15:0] PAT_TFF_C  = 16'hBFFC;
  localparam logic [15:0] PAT_TFF_V  = 16'h0000;
  localparam logic [15:0] PAT_TFF_A  = 16'h3FFC;
  localparam logic [1:0]  PAT_CUSTOM_TAG = 2'b10;
  localparam logic [11:0] WORD_AAA = 12'hAAA;
  localparam logic [11:0] WORD_555 = 12'h555;
  localparam logic [11:0] WORD_FFF = 12'hFFF;
  localparam logic [11:0] WORD_000 = 12'h000;

  // Latencies in clock cycles
  localparam int LAT_CORR_OFF = 38;
  localparam int LAT_CORR_ON  = 50;
  localparam int LAT_OVR      = 12;

  // Wake-up times and their cycle counts
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WAKE_SHUT_NS    = 2500000;
  localparam int WAKE_STBY_NS    = 100000;
  localparam int WAKE_DEEP_NS    = 20000;
  localparam int WAKE_LIGHT_NS   = 2000;
  localparam int WAKE_SHUT_CYC   = (WAKE_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_STBY_CYC   = (WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DEEP_CYC   = (WAKE_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_LIGHT_CYC  = (WAKE_LIGHT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W      = 17;

  // Full scale magnitude exponent (full scale = 2**FS_SHIFT)
  localparam int FS_SHIFT = 11;

  typedef enum logic [1:0] {
    SLEEP_SHUTDOWN,
    SLEEP_STANDBY,
    SLEEP_DEEP,
    SLEEP_LIGHT
  } atpopc_sleep_e;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAKING
  } atpopc_state_e;

  typedef enum logic [2:0] {
    PAT_NONE,
    PAT_ZERO,
    PAT_ONE,
    PAT_TOGGLE_AA,
    PAT_TOGGLE_FF,
    PAT_CUSTOM
  } atpopc_pat_e;

endpackage

//--- rtl/atpopc_core.sv
// Converter control: sleep modes, test patterns, fast over-range and correction loop control
// Function
// - Sleep mode held at 0x37; chosen mode entered while enable pin is low.
// - Enable high leaves sleep after 2.5 ms, 100 us, 20 us or 2 us.
// - 8000/0000/0000 gives all zeros; BFFC/3FFC/3FFC gives all ones.
// - 9554/2AA8/1554 toggles AAA/555; BFFC/0000/3FFC toggles FFF/000.
// - Over-range flag appears 12 cycles after a sample beyond threshold.
// - Threshold is full scale times threshold field divided by 16.
// - Threshold field resets to 15.
// - Correction loop enabled at register 1, reset through registers 3 and 26.
// - Correction loop is disabled after reset.
// - Restart bit high clears accumulators; writing it low starts the loop.
// - Data latency is 38 cycles, or 50 with correction enabled.
`timescale 1ns/100ps

module atpopc_core #(
  parameter int SAMPLE_W      = 12,
  parameter int WAKE_SHUT_CYC = atpopc_pkg::WAKE_SHUT_CYC
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // Register write port
  input  wire logic                reg_wr_en,
  input  wire logic [6:0]          reg_wr_addr,
  input  wire logic [15:0]         reg_wr_data,
  // Register read port
  input  wire logic                reg_rd_en,
  input  wire logic [6:0]          reg_rd_addr,
  output logic      [15:0]         reg_rd_data,
  // Converter side
  input  wire logic                enable_pin,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  // Output bus and status
  output logic      [SAMPLE_W-1:0] data_out,
  output logic                     overrange_flag_out,
  output logic                     sleep_active,
  output logic                     corr_acc_clear,
  output logic                     corr_running
);

  localparam int DL_DEPTH = atpopc_pkg::LAT_CORR_ON - 1;

  typedef struct packed {
    atpopc_pkg::atpopc_state_e                    st;
    logic [atpopc_pkg::WAKE_CNT_W-1:0]            wake_cnt;
    atpopc_pkg::atpopc_sleep_e                    sleep_sel;
    logic                                         high_perf_mode_one;
    logic                                         corr_en;
    logic                                         restart_a;
    logic                                         restart_b;
    logic                                         corr_run;
    logic                                         corr_clr;
    logic                                         sleep_flag;
    logic [3:0]                                   fast_overrange_threshold;
    logic [15:0]                                  pattern_control_word;
    logic [15:0]                                  custom_pattern_value;
    logic [15:0]                                  pattern_aux_word;
    logic                                         phase;
    logic [DL_DEPTH-1:0][SAMPLE_W-1:0]            dl;
    logic [atpopc_pkg::LAT_OVR-1:0]               ovr_pipe;
    logic [SAMPLE_W-1:0]                          data_out;
    logic [15:0]                                  rd_data;
  } atpopc_regs_s;

  atpopc_regs_s s;
  atpopc_regs_s next_s;

  // Wake-up count for each sleep mode
  function automatic logic [atpopc_pkg::WAKE_CNT_W-1:0] wake_cycles(input atpopc_pkg::atpopc_sleep_e m);
    case (m)
      atpopc_pkg::SLEEP_SHUTDOWN: wake_cycles = atpopc_pkg::WAKE_CNT_W'(WAKE_SHUT_CYC);
      atpopc_pkg::SLEEP_STANDBY:  wake_cycles = atpopc_pkg::WAKE_CNT_W'(atpopc_pkg::WAKE_STBY_CYC);
      atpopc_pkg::SLEEP_DEEP:     wake_cycles = atpopc_pkg::WAKE_CNT_W'(atpopc_pkg::WAKE_DEEP_CYC);
      default:                    wake_cycles = atpopc_pkg::WAKE_CNT_W'(atpopc_pkg::WAKE_LIGHT_CYC);
    endcase
  endfunction

  // True when the three pattern registers hold the given triple
  function automatic logic pat_match(input logic [15:0] c, input logic [15:0] v, input logic [15:0] a,
                                     input logic [15:0] ec, input logic [15:0] ev, input logic [15:0] ea);
    pat_match = (c == ec) && (v == ev) && (a == ea);
  endfunction

  atpopc_pkg::atpopc_pat_e pat_kind;
  logic                    pat_on;
  logic [SAMPLE_W-1:0]     pat_word;
  logic [SAMPLE_W-1:0]     mag;
  logic [15:0]             mag_scaled;
  logic [15:0]             trip_level;
  logic                    ovr_hit;
  logic                    wr_mode;
  logic                    wr_corr_a;
  logic                    wr_corr_b;

  assign wr_mode   = reg_wr_en && (reg_wr_addr == atpopc_pkg::ADDR_MODE_CTRL);
  assign wr_corr_a = reg_wr_en && (reg_wr_addr == atpopc_pkg::ADDR_CORR_CTRL_A);
  assign wr_corr_b = reg_wr_en && (reg_wr_addr == atpopc_pkg::ADDR_CORR_CTRL_B);

  // Pattern decode; exact table entries win over the generic custom form
  always_comb begin
    pat_kind = atpopc_pkg::PAT_NONE;
    if (pat_match(s.pattern_control_word, s.custom_pattern_value, s.pattern_aux_word,
                  atpopc_pkg::PAT_ZERO_C, atpopc_pkg::PAT_ZERO_V, atpopc_pkg::PAT_ZERO_A)) begin
      pat_kind = atpopc_pkg::PAT_ZERO;
    end else if (pat_match(s.pattern_control_word, s.custom_pattern_value, s.pattern_aux_word,
                           atpopc_pkg::PAT_ONE_C, atpopc_pkg::PAT_ONE_V, atpopc_pkg::PAT_ONE_A)) begin
      pat_kind = atpopc_pkg::PAT_ONE;
    end else if (pat_match(s.pattern_control_word, s.custom_pattern_value, s.pattern_aux_word,
                           atpopc_pkg::PAT_TAA_C, atpopc_pkg::PAT_TAA_V, atpopc_pkg::PAT_TAA_A)) begin
      pat_kind = atpopc_pkg::PAT_TOGGLE_AA;
    end else if (pat_match(s.pattern_control_word, s.custom_pattern_value, s.pattern_aux_word,
                           atpopc_pkg::PAT_TFF_C, atpopc_pkg::PAT_TFF_V, atpopc_pkg::PAT_TFF_A)) begin
      pat_kind = atpopc_pkg::PAT_TOGGLE_FF;
    end else if (s.pattern_control_word[15:14] == atpopc_pkg::PAT_CUSTOM_TAG) begin
      pat_kind = atpopc_pkg::PAT_CUSTOM;
    end
  end

  // Patterns are unavailable while high-performance mode one is on
  assign pat_on = !s.high_perf_mode_one && (pat_kind != atpopc_pkg::PAT_NONE);

  always_comb begin
    case (pat_kind)
      atpopc_pkg::PAT_ZERO:      pat_word = atpopc_pkg::WORD_000;
      atpopc_pkg::PAT_ONE:       pat_word = atpopc_pkg::WORD_FFF;
      atpopc_pkg::PAT_TOGGLE_AA: pat_word = s.phase ? atpopc_pkg::WORD_555 : atpopc_pkg::WORD_AAA;
      atpopc_pkg::PAT_TOGGLE_FF: pat_word = s.phase ? atpopc_pkg::WORD_000 : atpopc_pkg::WORD_FFF;
      atpopc_pkg::PAT_CUSTOM:    pat_word = s.custom_pattern_value[13:2];
      default:                   pat_word = atpopc_pkg::WORD_000;
    endcase
  end

  // Magnitude of the two's complement sample against full scale * field / 16
  // Negating the most negative sample wraps to 0x800, which still reads as full scale
  assign mag        = sample_in[SAMPLE_W-1] ? SAMPLE_W'(-sample_in) : sample_in;
  assign mag_scaled = {mag, 4'h0};
  assign trip_level = {1'b0, s.fast_overrange_threshold, 11'h000};
  assign ovr_hit    = mag_scaled > trip_level;

  always_comb begin
    next_s = s;

    // Register writes
    if (reg_wr_en) begin
      case (reg_wr_addr)
        atpopc_pkg::ADDR_MODE_CTRL: begin
          next_s.corr_en            = reg_wr_data[atpopc_pkg::CORR_EN_BIT];
          next_s.high_perf_mode_one = reg_wr_data[atpopc_pkg::HP1_BIT];
        end
        atpopc_pkg::ADDR_CORR_CTRL_A: next_s.restart_a = reg_wr_data[atpopc_pkg::RESTART_BIT];
        atpopc_pkg::ADDR_CORR_CTRL_B: next_s.restart_b = reg_wr_data[atpopc_pkg::RESTART_BIT];
        atpopc_pkg::ADDR_OVR_THRESH:  next_s.fast_overrange_threshold = reg_wr_data[3:0];
        atpopc_pkg::ADDR_SLEEP_CTRL:  next_s.sleep_sel = atpopc_pkg::atpopc_sleep_e'(reg_wr_data[1:0]);
        atpopc_pkg::ADDR_PAT_CTRL:    next_s.pattern_control_word = reg_wr_data;
        atpopc_pkg::ADDR_PAT_VALUE:   next_s.custom_pattern_value = reg_wr_data;
        atpopc_pkg::ADDR_PAT_AUX:     next_s.pattern_aux_word = reg_wr_data;
        default: ;
      endcase
    end

    // Registered readback; unmapped addresses read zero
    if (reg_rd_en) begin
      next_s.rd_data = 16'h0000;
      case (reg_rd_addr)
        atpopc_pkg::ADDR_MODE_CTRL: begin
          next_s.rd_data[atpopc_pkg::CORR_EN_BIT] = s.corr_en;
          next_s.rd_data[atpopc_pkg::HP1_BIT]     = s.high_perf_mode_one;
        end
        atpopc_pkg::ADDR_CORR_CTRL_A: next_s.rd_data[atpopc_pkg::RESTART_BIT] = s.restart_a;
        atpopc_pkg::ADDR_CORR_CTRL_B: next_s.rd_data[atpopc_pkg::RESTART_BIT] = s.restart_b;
        atpopc_pkg::ADDR_OVR_THRESH:  next_s.rd_data[3:0] = s.fast_overrange_threshold;
        atpopc_pkg::ADDR_SLEEP_CTRL: begin
          next_s.rd_data[1:0] = s.sleep_sel;
          next_s.rd_data[atpopc_pkg::SLEEP_STATE_LSB +: 2] = s.st;
        end
        atpopc_pkg::ADDR_PAT_CTRL:  next_s.rd_data = s.pattern_control_word;
        atpopc_pkg::ADDR_PAT_VALUE: next_s.rd_data = s.custom_pattern_value;
        atpopc_pkg::ADDR_PAT_AUX:   next_s.rd_data = s.pattern_aux_word;
        default: ;
      endcase
    end

    // Sleep sequencing; a low enable during wake-up goes straight back to sleep
    case (s.st)
      atpopc_pkg::ST_ACTIVE: begin
        if (!enable_pin) begin
          next_s.st = atpopc_pkg::ST_SLEEP;
        end
      end
      atpopc_pkg::ST_SLEEP: begin
        if (enable_pin) begin
          next_s.st       = atpopc_pkg::ST_WAKING;
          next_s.wake_cnt = wake_cycles(s.sleep_sel);
        end
      end
      atpopc_pkg::ST_WAKING: begin
        if (!enable_pin) begin
          next_s.st = atpopc_pkg::ST_SLEEP;
        end else if (s.wake_cnt <= atpopc_pkg::WAKE_CNT_W'(1)) begin
          next_s.st = atpopc_pkg::ST_ACTIVE;
        end else begin
          next_s.wake_cnt = s.wake_cnt - atpopc_pkg::WAKE_CNT_W'(1);
        end
      end
      default: next_s.st = atpopc_pkg::ST_SLEEP;
    endcase

    // Status kept in its own flop so the pin never shows decode glitches
    next_s.sleep_flag = (next_s.st == atpopc_pkg::ST_SLEEP);

    // Correction loop: clear while either restart bit is high, run once both fall with the loop on
    next_s.corr_clr = next_s.restart_a || next_s.restart_b;
    if (!next_s.corr_en || next_s.corr_clr) begin
      next_s.corr_run = 1'b0;
    end else if (s.corr_clr) begin
      next_s.corr_run = 1'b1;
    end

    // Sample delay line and over-range pipe
    next_s.dl       = {s.dl[DL_DEPTH-2:0], sample_in};
    next_s.ovr_pipe = {s.ovr_pipe[atpopc_pkg::LAT_OVR-2:0], ovr_hit};
    next_s.phase    = !s.phase;

    // Output word; tap chosen so the bus sees 38 or 50 cycles of latency
    if (s.st != atpopc_pkg::ST_ACTIVE) begin
      next_s.data_out = '0;
    end else if (pat_on) begin
      next_s.data_out = pat_word;
    end else if (s.corr_en) begin
      next_s.data_out = s.dl[atpopc_pkg::LAT_CORR_ON-2];
    end else begin
      next_s.data_out = s.dl[atpopc_pkg::LAT_CORR_OFF-2];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s                          <= '0;
      s.st                       <= atpopc_pkg::ST_ACTIVE;
      s.sleep_sel                <= atpopc_pkg::SLEEP_SHUTDOWN;
      s.high_perf_mode_one       <= atpopc_pkg::HP1_RESET;
      s.fast_overrange_threshold <= atpopc_pkg::THRESH_RESET;
      s.pattern_control_word     <= atpopc_pkg::PAT_RESET;
      s.custom_pattern_value     <= atpopc_pkg::PAT_RESET;
      s.pattern_aux_word         <= atpopc_pkg::PAT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rd_data        = s.rd_data;
  assign data_out           = s.data_out;
  assign overrange_flag_out = s.ovr_pipe[atpopc_pkg::LAT_OVR-1];
  assign sleep_active       = s.sleep_flag;
  assign corr_acc_clear     = s.corr_clr;
  assign corr_running       = s.corr_run;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ovr_delay_exact: assert property (ovr_hit |-> ##12 overrange_flag_out)
    else $error("over-range flag missing 12 cycles after hit");
  a_sleep_on_low: assert property ((s.st == atpopc_pkg::ST_ACTIVE && !enable_pin) |=> sleep_active)
    else $error("sleep not entered on low enable");
  a_wake_load: assert property ((sleep_active && enable_pin) |=>
                                (s.st == atpopc_pkg::ST_WAKING && s.wake_cnt == wake_cycles($past(s.sleep_sel))))
    else $error("wake count not loaded for selected mode");
  a_light_wake_time: assert property ((sleep_active && enable_pin && s.sleep_sel == atpopc_pkg::SLEEP_LIGHT)
                                      ##1 enable_pin[*8] |-> s.st == atpopc_pkg::ST_WAKING)
    else $error("light sleep woke too early");
  a_thresh_reset: assert property ($rose(reset_n) |-> s.fast_overrange_threshold == 4'hF)
    else $error("threshold reset value wrong");
  a_corr_off_reset: assert property ($rose(reset_n) |-> (!corr_running && !s.corr_en))
    else $error("correction enabled after reset");
  a_restart_clear: assert property ((wr_corr_a && reg_wr_data[atpopc_pkg::RESTART_BIT]) |=>
                                    (corr_acc_clear && !corr_running) ##1 !corr_running)
    else $error("restart did not clear accumulators");
  a_restart_start: assert property ((corr_acc_clear && s.corr_en && !wr_mode && !wr_corr_b && wr_corr_a &&
                                     !s.restart_b && !reg_wr_data[atpopc_pkg::RESTART_BIT]) |=> ##1 corr_running)
    else $error("loop did not start after restart fell");
  a_lat_off: assert property (($past(s.st) == atpopc_pkg::ST_ACTIVE && !$past(pat_on) && !$past(s.corr_en)
                               && $past(reset_n, 39)) |-> data_out == $past(sample_in, 38))
    else $error("latency without correction not 38");
  a_lat_on: assert property (($past(s.st) == atpopc_pkg::ST_ACTIVE && !$past(pat_on) && $past(s.corr_en)
                              && $past(reset_n, 51)) |-> data_out == $past(sample_in, 50))
    else $error("latency with correction not 50");
  a_pat_constant: assert property ((s.st == atpopc_pkg::ST_ACTIVE && pat_on && pat_kind == atpopc_pkg::PAT_ONE)
                                   |=> data_out == 12'hFFF)
    else $error("all-ones pattern wrong");
  a_pat_toggle: assert property ((s.st == atpopc_pkg::ST_ACTIVE && pat_on && pat_kind == atpopc_pkg::PAT_TOGGLE_AA)
                                 [*2] |=> (data_out == 12'hAAA || data_out == 12'h555) &&
                                 data_out != $past(data_out))
    else $error("toggle pattern not alternating");
  a_pat_custom: assert property ((s.st == atpopc_pkg::ST_ACTIVE && pat_on && pat_kind == atpopc_pkg::PAT_CUSTOM)
                                 |=> data_out == $past(s.custom_pattern_value[13:2]))
    else $error("custom pattern value wrong");

endmodule

//--- tb/atpopc_far.sv
// Far-side model: converter sample source that ramps one step per clock
`timescale 1ns/100ps

module atpopc_far (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Converter samples
  output logic      [11:0] sample_in
);
  // A ramp makes each word unique for 4096 cycles, so a latency slip cannot hide
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sample_in <= 12'h000;
    end else begin
      sample_in <= sample_in + 12'h001;
    end
  end
endmodule

//--- tb/atpopc_core_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/100ps

module atpopc_core_tb;
  logic        clk_sys;
  logic        reset_n;
  logic        reg_wr_en;
  logic [6:0]  reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic        reg_rd_en;
  logic [6:0]  reg_rd_addr;
  logic [15:0] reg_rd_data;
  logic        enable_pin;
  logic [11:0] sample_in;
  logic [11:0] data_out;
  logic        overrange_flag_out;
  logic        sleep_active;
  logic        corr_acc_clear;
  logic        corr_running;
  int          mismatches;
  int          n_checks;

  atpopc_far atpopc_far_i (.clk_sys(clk_sys), .reset_n(reset_n), .sample_in(sample_in));

  // Shutdown wake-up shortened to 20 cycles to keep the run brief
  atpopc_core #(.SAMPLE_W(12), .WAKE_SHUT_CYC(20)) atpopc_core_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .enable_pin(enable_pin), .sample_in(sample_in),
    .data_out(data_out), .overrange_flag_out(overrange_flag_out), .sleep_active(sleep_active),
    .corr_acc_clear(corr_acc_clear), .corr_running(corr_running));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr_en   <= 1'b1;
    reg_wr_addr <= a;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en   <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd_en   <= 1'b1;
    reg_rd_addr <= a;
    @(posedge clk_sys);
    reg_rd_en   <= 1'b0;
    @(negedge clk_sys);
    chk(32'(reg_rd_data), 32'(exp));
  endtask

  // Output word must trail the ramp by exactly lat cycles; wrap kept at 12 bits
  task automatic chk_ramp(input int lat);
    repeat (3) begin
      @(negedge clk_sys);
      chk(32'(data_out), 32'(12'(sample_in - 12'(lat))));
    end
  endtask

  function automatic logic ovr_exp(input logic [11:0] s, input int th);
    int m;
    m = s[11] ? 4096 - int'(s) : int'(s);
    return (m * 16) > (th * 2048);
  endfunction

  task automatic chk_ovr(input int th);
    repeat (20) @(negedge clk_sys);
    repeat (4096) begin
      @(negedge clk_sys);
      chk(32'(overrange_flag_out), 32'(ovr_exp(sample_in - 12'h00C, th)));
    end
  endtask

  task automatic t_reset();
    rd_chk(7'h2F, 16'h000F);
    rd_chk(7'h01, 16'h0002);
    rd_chk(7'h3C, 16'h0000);
    rd_chk(7'h10, 16'h0000);
    repeat (45) @(posedge clk_sys);
    chk_ramp(38);
  endtask

  // Two consecutive words must be w0,w1 in either phase; equal words mean a constant
  task automatic pat(input logic [15:0] c, input logic [15:0] v, input logic [15:0] a,
                     input logic [11:0] w0, input logic [11:0] w1);
    logic [11:0] d0;
    wr(7'h01, 16'h0000);
    wr(7'h3C, c);
    wr(7'h3D, v);
    wr(7'h3E, a);
    repeat (3) @(negedge clk_sys);
    d0 = data_out;
    @(negedge clk_sys);
    chk({d0, data_out}, (d0 === w0) ? {w0, w1} : {w1, w0});
  endtask

  task automatic t_patterns();
    pat(16'h8000, 16'h0000, 16'h0000, 12'h000, 12'h000);
    pat(16'hBFFC, 16'h3FFC, 16'h3FFC, 12'hFFF, 12'hFFF);
    pat(16'h9554, 16'h2AA8, 16'h1554, 12'hAAA, 12'h555);
    pat(16'hBFFC, 16'h0000, 16'h3FFC, 12'hFFF, 12'h000);
    pat(16'h8000, 16'h1234, 16'h0000, 12'h48D, 12'h48D);
    wr(7'h01, 16'h0002);
    @(posedge clk_sys);
    chk_ramp(38);
    wr(7'h3C, 16'h0000);
    wr(7'h3D, 16'h0000);
    wr(7'h3E, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk_ramp(38);
  endtask

  task automatic t_overrange();
    chk_ovr(15);
    wr(7'h2F, 16'h0008);
    chk_ovr(8);
    wr(7'h2F, 16'h000F);
  endtask

  // Each sleep mode: entry while enable is low, then its own wake-up span
  task automatic t_sleep();
    int wk[4] = '{20, 2500, 500, 50};
    for (int m = 0; m < 4; m++) begin
      wr(7'h37, 16'(m));
      @(posedge clk_sys);
      enable_pin <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(32'(sleep_active), 32'h1);
      chk(32'(data_out), 32'h0);
      rd_chk(7'h37, 16'h0010 | 16'(m));
      @(posedge clk_sys);
      enable_pin <= 1'b1;
      repeat (wk[m] - 8) @(posedge clk_sys);
      rd_chk(7'h37, 16'h0020 | 16'(m));
      repeat (12) @(posedge clk_sys);
      rd_chk(7'h37, 16'(m));
      chk(32'(sleep_active), 32'h0);
    end
  endtask

  task automatic t_corr();
    wr(7'h01, 16'h8002);
    wr(7'h03, 16'h4000);
    repeat (2) @(negedge clk_sys);
    chk({corr_acc_clear, corr_running}, 2'b10);
    wr(7'h03, 16'h0000);
    repeat (3) @(negedge clk_sys);
    chk({corr_acc_clear, corr_running}, 2'b01);
    wr(7'h1A, 16'h4000);
    repeat (2) @(negedge clk_sys);
    chk({corr_acc_clear, corr_running}, 2'b10);
    wr(7'h1A, 16'h0000);
    repeat (60) @(posedge clk_sys);
    chk(32'(corr_running), 32'h1);
    chk_ramp(50);
    wr(7'h01, 16'h0002);
    repeat (2) @(negedge clk_sys);
    chk(32'(corr_running), 32'h0);
    repeat (60) @(posedge clk_sys);
    chk_ramp(38);
  endtask

  initial begin
    mismatches  = 0;
    n_checks    = 0;
    reset_n     = 1'b0;
    reg_wr_en   = 1'b0;
    reg_wr_addr = 7'h00;
    reg_wr_data = 16'h0000;
    reg_rd_en   = 1'b0;
    reg_rd_addr = 7'h00;
    enable_pin  = 1'b1;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_patterns();
    t_overrange();
    t_sleep();
    t_corr();
    finish_test();
  end

  // Planned run is near 11700 cycles; allow roughly two and a half times
  initial begin
    #(30000 * 40);
    mismatches++;
    finish_test();
  end
endmodule
